// file: rtl/lfg_pkg.sv
// lfg_pkg: constants, codes and reset values for the link-fault status bank
package lfg_pkg;

    // ------------------------------------------------------------------
    // widths and bit positions
    // ------------------------------------------------------------------
    localparam int          LF_W          = 16;
    localparam int          NUM_LINKS     = 7;
    localparam int          ESE_W         = 8;
    localparam int          LF_BIT_REF    = 0;
    localparam int          LF_BIT_RFSRC  = 1;
    localparam int          LF_BIT_OUTPUT = 2;
    localparam int          LF_BIT_INPUT1 = 3;
    localparam int          LF_BIT_INPUT2 = 4;
    localparam int          LF_BIT_IQMOD  = 5;
    localparam int          LF_BIT_CELL   = 6;
    localparam int          ESR_BIT_CMD   = 5;
    localparam int          ESR_BIT_USER  = 6;
    localparam int          ESR_BIT_PWR   = 7;
    localparam int          ROUTE_COMM    = 0;
    localparam int          ROUTE_HW      = 1;

    // ------------------------------------------------------------------
    // masks of implemented bits; everything else reads zero
    // ------------------------------------------------------------------
    localparam logic [15:0] LF_USED_MASK  = 16'h007F;
    localparam logic [15:0] ESR_USED_MASK = 16'h00A0;

    // ------------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------------
    localparam logic [15:0] LF_PTR_RST    = 16'h007F;
    localparam logic [15:0] LF_NTR_RST    = 16'h0000;
    localparam logic [15:0] LF_ENAB_RST   = 16'h0000;
    localparam logic [15:0] ESR_RST       = 16'h0080;
    localparam logic [7:0]  ESE_RST       = 8'h00;
    localparam logic [1:0]  ROUTE_RST     = 2'h0;

    // ------------------------------------------------------------------
    // timing: cycles the fault capture window stays open
    // ------------------------------------------------------------------
    localparam logic [7:0]  CHECK_LEN     = 8'h10;

    // ------------------------------------------------------------------
    // command codes from the remote command parser
    // ------------------------------------------------------------------
    typedef enum logic [3:0] {
        LFG_NOP      = 4'h0,
        LFG_RD_COND  = 4'h1,
        LFG_RD_PTR   = 4'h2,
        LFG_WR_PTR   = 4'h3,
        LFG_RD_NTR   = 4'h4,
        LFG_WR_NTR   = 4'h5,
        LFG_RD_EVENT = 4'h6,
        LFG_RD_ENAB  = 4'h7,
        LFG_WR_ENAB  = 4'h8,
        LFG_RD_ESR   = 4'h9,
        LFG_RD_ESE   = 4'hA,
        LFG_WR_ESE   = 4'hB,
        LFG_CLS      = 4'hC,
        LFG_SELFTEST = 4'hD,
        LFG_WR_ROUTE = 4'hE,
        LFG_RD_ROUTE = 4'hF
    } lfg_cmd_t;

endpackage

// file: rtl/lfg_status_bank.sv
// lfg_status_bank: link-fault and standard event status register bank
`timescale 1ns/1ps
module lfg_status_bank
    import lfg_pkg::*;
(
    // clock and reset
    input  wire logic                        CLK_I,
    input  wire logic                        RESETN_I,
    // command port from the remote parser
    input  wire logic                        CMD_VALID_I,
    input  wire lfg_pkg::lfg_cmd_t           CMD_OP_I,
    input  wire logic [lfg_pkg::LF_W-1:0]    CMD_DATA_I,
    output logic                             RSP_VALID_O,
    output logic [lfg_pkg::LF_W-1:0]         RSP_DATA_O,
    // serial bus receiver fault levels, asynchronous
    input  wire logic [lfg_pkg::NUM_LINKS-1:0] LINK_FAULT_I,
    // parser error pulses, same clock
    input  wire logic                        SYNTAX_ERR_I,
    input  wire logic                        SEMANTIC_ERR_I,
    input  wire logic                        GET_IN_MSG_I,
    // summaries toward the status byte, and the capture-window flag
    output logic                             LF_SUMMARY_O,
    output logic                             STB_LINK_FAULT_O,
    output logic                             STD_SUMMARY_O,
    output logic                             CHECK_ACTIVE_O
);
    import lfg_pkg::*;

    typedef struct packed {
        logic [NUM_LINKS-1:0] sync1;
        logic [NUM_LINKS-1:0] sync2;
        logic [7:0]           check_cnt;
        logic [LF_W-1:0]      lf_cond;
        logic [LF_W-1:0]      lf_ptr;
        logic [LF_W-1:0]      lf_ntr;
        logic [LF_W-1:0]      lf_event;
        logic [LF_W-1:0]      lf_enab;
        logic [LF_W-1:0]      esr;
        logic [ESE_W-1:0]     ese;
        logic [1:0]           route;
        logic                 rsp_valid;
        logic [LF_W-1:0]      rsp_data;
    } lfg_state_t;

    lfg_state_t      s_q;
    lfg_state_t      s_d;
    logic [LF_W-1:0] lf_rise;
    logic [LF_W-1:0] lf_fall;
    logic [LF_W-1:0] lf_set;
    logic [LF_W-1:0] esr_set;
    logic            fire;

    assign fire = CMD_VALID_I;

    // ------------------------------------------------------------------
    // next-state logic
    // ------------------------------------------------------------------
    always_comb begin
        s_d = s_q;
        // stage one feeds stage two only
        s_d.sync1 = LINK_FAULT_I;
        s_d.sync2 = s_q.sync1;

        // capture window: opened by reset, reopened by self-test
        if (fire && CMD_OP_I == LFG_SELFTEST) begin
            s_d.check_cnt = CHECK_LEN;
        end else if (s_q.check_cnt != 8'h00) begin
            s_d.check_cnt = s_q.check_cnt - 8'h01;
        end
        if (s_q.check_cnt != 8'h00) begin
            // receiver order is fixed by the synchroniser bit order
            s_d.lf_cond = {9'h000, s_q.sync2} & LF_USED_MASK;
        end

        lf_rise = s_d.lf_cond & ~s_q.lf_cond;
        lf_fall = ~s_d.lf_cond & s_q.lf_cond;
        lf_set  = ((lf_rise & s_q.lf_ptr) | (lf_fall & s_q.lf_ntr))
                  & LF_USED_MASK;

        esr_set = 16'h0000;
        esr_set[ESR_BIT_CMD] = SYNTAX_ERR_I | SEMANTIC_ERR_I
                               | GET_IN_MSG_I;

        s_d.rsp_valid = 1'b0;
        s_d.rsp_data  = s_q.rsp_data;

        if (fire) begin
            unique case (CMD_OP_I)
                LFG_RD_COND: begin
                    s_d.rsp_valid = 1'b1;
                    s_d.rsp_data  = s_q.lf_cond;
                end
                LFG_RD_PTR: begin
                    s_d.rsp_valid = 1'b1;
                    s_d.rsp_data  = s_q.lf_ptr;
                end
                LFG_WR_PTR: begin
                    s_d.lf_ptr = CMD_DATA_I & LF_USED_MASK;
                end
                LFG_RD_NTR: begin
                    s_d.rsp_valid = 1'b1;
                    s_d.rsp_data  = s_q.lf_ntr;
                end
                LFG_WR_NTR: begin
                    s_d.lf_ntr = CMD_DATA_I & LF_USED_MASK;
                end
                LFG_RD_EVENT: begin
                    s_d.rsp_valid = 1'b1;
                    s_d.rsp_data  = s_q.lf_event;
                    s_d.lf_event  = 16'h0000;
                end
                LFG_RD_ENAB: begin
                    s_d.rsp_valid = 1'b1;
                    s_d.rsp_data  = s_q.lf_enab;
                end
                LFG_WR_ENAB: begin
                    s_d.lf_enab = CMD_DATA_I & LF_USED_MASK;
                end
                LFG_RD_ESR: begin
                    s_d.rsp_valid = 1'b1;
                    s_d.rsp_data  = s_q.esr;
                    // reading also retires the power-on flag
                    s_d.esr       = 16'h0000;
                end
                LFG_RD_ESE: begin
                    s_d.rsp_valid = 1'b1;
                    s_d.rsp_data  = {8'h00, s_q.ese};
                end
                LFG_WR_ESE: begin
                    s_d.ese = CMD_DATA_I[ESE_W-1:0];
                end
                LFG_CLS: begin
                    s_d.lf_event = 16'h0000;
                    s_d.esr      = 16'h0000;
                end
                LFG_WR_ROUTE: begin
                    s_d.route = CMD_DATA_I[1:0];
                end
                LFG_RD_ROUTE: begin
                    s_d.rsp_valid = 1'b1;
                    s_d.rsp_data  = {14'h0000, s_q.route};
                end
                LFG_NOP, LFG_SELFTEST: begin
                end
            endcase
        end

        // new events win over a clear in the same cycle
        s_d.lf_event = (s_d.lf_event | lf_set) & LF_USED_MASK;
        // user-request bit is masked out here, so it can never set
        s_d.esr = (s_d.esr | esr_set) & ESR_USED_MASK;
    end

    // ------------------------------------------------------------------
    // state register; power-on bit comes up set from reset
    // ------------------------------------------------------------------
    always_ff @(posedge CLK_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            s_q.sync1     <= '0;
            s_q.sync2     <= '0;
            s_q.check_cnt <= CHECK_LEN;
            s_q.lf_cond   <= 16'h0000;
            s_q.lf_ptr    <= LF_PTR_RST;
            s_q.lf_ntr    <= LF_NTR_RST;
            s_q.lf_event  <= 16'h0000;
            s_q.lf_enab   <= LF_ENAB_RST;
            s_q.esr       <= ESR_RST;
            s_q.ese       <= ESE_RST;
            s_q.route     <= ROUTE_RST;
            s_q.rsp_valid <= 1'b0;
            s_q.rsp_data  <= 16'h0000;
        end else begin
            s_q <= s_d;
        end
    end

    // ------------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------------
    assign RSP_VALID_O      = s_q.rsp_valid;
    assign RSP_DATA_O       = s_q.rsp_data;
    assign LF_SUMMARY_O     = |(s_q.lf_event & s_q.lf_enab);
    assign STB_LINK_FAULT_O = LF_SUMMARY_O & s_q.route[ROUTE_COMM]
                              & s_q.route[ROUTE_HW];
    assign STD_SUMMARY_O    = |(s_q.esr[ESE_W-1:0] & s_q.ese);
    assign CHECK_ACTIVE_O   = (s_q.check_cnt != 8'h00);

    // ------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (!RESETN_I);

    sequence s_cmd(lfg_cmd_t op);
        fire && CMD_OP_I == op;
    endsequence

    sequence s_wr_ptr;
        s_cmd(LFG_WR_PTR);
    endsequence

    sequence s_rd_ptr;
        s_cmd(LFG_RD_PTR);
    endsequence

    property p_cond_map;
        CHECK_ACTIVE_O |=> s_q.lf_cond == {9'h000, $past(s_q.sync2)};
    endproperty
    a_cond_map: assert property (p_cond_map)
        else $error("condition word does not follow receivers");

    property p_cond_hold;
        (!CHECK_ACTIVE_O && !(fire && CMD_OP_I == LFG_SELFTEST))
            |=> $stable(s_q.lf_cond) ##1 $stable(s_q.lf_cond);
    endproperty
    a_cond_hold: assert property (p_cond_hold)
        else $error("condition changed outside capture window");

    property p_selftest_window;
        s_cmd(LFG_SELFTEST) |=> CHECK_ACTIVE_O [*8];
    endproperty
    a_selftest_window: assert property (p_selftest_window)
        else $error("self-test did not open capture window");

    property p_stb_route;
        STB_LINK_FAULT_O |-> (s_q.route == 2'h3 && LF_SUMMARY_O);
    endproperty
    a_stb_route: assert property (p_stb_route)
        else $error("status byte bit without both routing enables");

    property p_stb_on;
        (LF_SUMMARY_O && s_q.route == 2'h3) |-> STB_LINK_FAULT_O;
    endproperty
    a_stb_on: assert property (p_stb_on)
        else $error("enabled link summary missing from status byte");

    property p_reserved_zero;
        RSP_DATA_O[15] == 1'b0 && (s_q.lf_event & ~LF_USED_MASK) == 16'h0000;
    endproperty
    a_reserved_zero: assert property (p_reserved_zero)
        else $error("reserved bit reads one");

    property p_cls_clears;
        s_cmd(LFG_CLS) |=> (s_q.lf_event & ~$past(lf_set)) == 16'h0000;
    endproperty
    a_cls_clears: assert property (p_cls_clears)
        else $error("clear-status left event bits set");

    property p_query_clears;
        s_cmd(LFG_RD_EVENT) |=> RSP_VALID_O
            && RSP_DATA_O == $past(s_q.lf_event)
            && (s_q.lf_event & ~$past(lf_set)) == 16'h0000;
    endproperty
    a_query_clears: assert property (p_query_clears)
        else $error("event query did not return and clear");

    // one idle cycle between write and read, as the controller spaces them
    property p_ptr_back;
        s_wr_ptr ##1 !fire ##1 s_rd_ptr |=>
            RSP_VALID_O && RSP_DATA_O == ($past(CMD_DATA_I, 3) & LF_USED_MASK);
    endproperty
    a_ptr_back: assert property (p_ptr_back)
        else $error("rising filter did not read back");

    property p_pwr_read;
        s_cmd(LFG_RD_ESR) |=> s_q.esr[ESR_BIT_PWR] == 1'b0;
    endproperty
    a_pwr_read: assert property (p_pwr_read)
        else $error("power-on bit survived a read");

    property p_user_zero;
        s_q.esr[ESR_BIT_USER] == 1'b0;
    endproperty
    a_user_zero: assert property (p_user_zero)
        else $error("user-request bit set");

    property p_cmd_err;
        (SYNTAX_ERR_I || SEMANTIC_ERR_I || GET_IN_MSG_I)
            |=> s_q.esr[ESR_BIT_CMD];
    endproperty
    a_cmd_err: assert property (p_cmd_err)
        else $error("command error bit not set");

    property p_summary;
        LF_SUMMARY_O == ((s_q.lf_event & s_q.lf_enab) != 16'h0000);
    endproperty
    a_summary: assert property (p_summary)
        else $error("link summary wrong");

    property p_edge_sets;
        ((s_q.lf_cond & ~$past(s_q.lf_cond) & $past(s_q.lf_ptr))
            & ~s_q.lf_event) == 16'h0000;
    endproperty
    a_edge_sets: assert property (p_edge_sets)
        else $error("filtered rising edge lost");

    property p_cond_read;
        s_cmd(LFG_RD_COND) |=> RSP_VALID_O
            && RSP_DATA_O == $past(s_q.lf_cond);
    endproperty
    a_cond_read: assert property (p_cond_read)
        else $error("condition read returned wrong value");

endmodule

// file: verif/lfg_ctrl_model.sv
// lfg_ctrl_model: remote controller issuing status commands and parser pulses
`timescale 1ns/1ps
module lfg_ctrl_model
    import lfg_pkg::*;
(
    // clock
    input  wire logic                     clk_i,
    // command side
    output logic                          cmd_valid_o,
    output lfg_pkg::lfg_cmd_t             cmd_op_o,
    output logic [lfg_pkg::LF_W-1:0]      cmd_data_o,
    input  wire logic                     rsp_valid_i,
    input  wire logic [lfg_pkg::LF_W-1:0] rsp_data_i,
    // parser error pulses: syntax, semantic, trigger in message
    output logic [2:0]                    err_o
);
    initial begin
        cmd_valid_o = 1'b0;
        cmd_op_o    = LFG_NOP;
        cmd_data_o  = 16'h0000;
        err_o       = 3'h0;
    end

    // ------------------------------------------------------------------
    // command cycles
    // ------------------------------------------------------------------
    // data is inverted once released so a stale word is never reused
    task automatic send(input lfg_cmd_t op, input logic [15:0] d);
        @(posedge clk_i);
        #1;
        cmd_valid_o = 1'b1;
        cmd_op_o    = op;
        cmd_data_o  = d;
        @(posedge clk_i);
        #1;
        cmd_valid_o = 1'b0;
        cmd_op_o    = LFG_NOP;
        cmd_data_o  = ~d;
    endtask

    // answer stands only in the cycle after the taking edge
    task automatic query(input lfg_cmd_t op, output logic [15:0] d,
                         output logic v);
        send(op, 16'h0000);
        v = rsp_valid_i;
        d = rsp_data_i;
    endtask

    task automatic pulse(input int k);
        @(posedge clk_i);
        #1;
        err_o[k] = 1'b1;
        @(posedge clk_i);
        #1;
        err_o[k] = 1'b0;
    endtask
endmodule

// file: verif/lfg_status_bank_tb.sv
// lfg_status_bank_tb: self-checking bench for the link-fault status bank
`timescale 1ns/1ps
`define CHK(g, e) begin \
    tests_run++; \
    if ((g) !== (e)) begin \
        num_errors++; \
        $display("mismatch at %0t: got %0h expected %0h", $time, (g), (e)); \
    end \
end
module lfg_status_bank_tb;
    import lfg_pkg::*;
    logic              CLK_I;
    logic              RESETN_I;
    logic              cmd_valid;
    lfg_cmd_t          cmd_op;
    logic [LF_W-1:0]   cmd_data;
    logic              rsp_valid;
    logic [LF_W-1:0]   rsp_data;
    logic [NUM_LINKS-1:0] link_fault;
    logic [2:0]        err;
    logic              lf_sum;
    logic              stb_bit;
    logic              std_sum;
    logic              chk_act;
    int                num_errors = 0;
    int                tests_run  = 0;
    int                cycles     = 0;

    initial begin
        CLK_I = 1'b0;
        forever #20 CLK_I = ~CLK_I;
    end

    lfg_status_bank u_dut (
        .CLK_I            (CLK_I),
        .RESETN_I         (RESETN_I),
        .CMD_VALID_I      (cmd_valid),
        .CMD_OP_I         (cmd_op),
        .CMD_DATA_I       (cmd_data),
        .RSP_VALID_O      (rsp_valid),
        .RSP_DATA_O       (rsp_data),
        .LINK_FAULT_I     (link_fault),
        .SYNTAX_ERR_I     (err[0]),
        .SEMANTIC_ERR_I   (err[1]),
        .GET_IN_MSG_I     (err[2]),
        .LF_SUMMARY_O     (lf_sum),
        .STB_LINK_FAULT_O (stb_bit),
        .STD_SUMMARY_O    (std_sum),
        .CHECK_ACTIVE_O   (chk_act)
    );

    lfg_ctrl_model u_ctrl (
        .clk_i       (CLK_I),
        .cmd_valid_o (cmd_valid),
        .cmd_op_o    (cmd_op),
        .cmd_data_o  (cmd_data),
        .rsp_valid_i (rsp_valid),
        .rsp_data_i  (rsp_data),
        .err_o       (err)
    );

    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------
    // run needs under a thousand cycles; ceiling leaves ample margin
    always @(posedge CLK_I) begin
        cycles++;
        if (cycles == 3000) begin
            num_errors++;
            summarize();
        end
    end

    task automatic summarize;
        $display("comparisons %0d, mismatches %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    task automatic rdchk(input lfg_cmd_t op, input logic [15:0] e);
        logic [15:0] d;
        logic        rv;
        u_ctrl.query(op, d, rv);
        `CHK(rv, 1'b1)
        `CHK(d, e)
    endtask

    task automatic selftest;
        u_ctrl.send(LFG_SELFTEST, 16'h0000);
        `CHK(chk_act, 1'b1)
        repeat (20) @(posedge CLK_I);
        #1;
        `CHK(chk_act, 1'b0)
    endtask

    // ------------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------------
    initial begin
        RESETN_I   = 1'b0;
        link_fault = 7'h01;
        repeat (20) @(posedge CLK_I);
        #1;
        RESETN_I = 1'b1;
        repeat (20) @(posedge CLK_I);
        rdchk(LFG_RD_COND, 16'h0001);
        rdchk(LFG_RD_EVENT, 16'h0001);
        rdchk(LFG_RD_EVENT, 16'h0000);
        rdchk(LFG_RD_PTR, 16'h007F);
        rdchk(LFG_RD_NTR, 16'h0000);
        rdchk(LFG_RD_ENAB, 16'h0000);
        rdchk(LFG_RD_ESR, 16'h0080);
        rdchk(LFG_RD_ESR, 16'h0000);
        rdchk(LFG_RD_ESE, 16'h0000);
        rdchk(LFG_RD_ROUTE, 16'h0000);
        // fault changes outside a window leave the condition alone
        link_fault = 7'h00;
        repeat (10) @(posedge CLK_I);
        rdchk(LFG_RD_COND, 16'h0001);
        u_ctrl.send(LFG_WR_PTR, 16'hFFFF);
        rdchk(LFG_RD_PTR, 16'h007F);
        u_ctrl.send(LFG_WR_NTR, 16'hFFFF);
        rdchk(LFG_RD_NTR, 16'h007F);
        u_ctrl.send(LFG_WR_ENAB, 16'hFFFF);
        rdchk(LFG_RD_ENAB, 16'h007F);
        u_ctrl.send(LFG_WR_ENAB, 16'h0000);
        u_ctrl.send(LFG_WR_NTR, 16'h0000);
        selftest();
        rdchk(LFG_RD_EVENT, 16'h0000);
        // walk one fault across every link; falls are filtered out
        for (int i = 0; i < NUM_LINKS; i++) begin
            link_fault = 7'h01 << i;
            selftest();
            rdchk(LFG_RD_COND, 16'h0001 << i);
            rdchk(LFG_RD_COND, 16'h0001 << i);
            rdchk(LFG_RD_EVENT, 16'h0001 << i);
        end
        u_ctrl.send(LFG_WR_PTR, 16'h0000);
        u_ctrl.send(LFG_WR_NTR, 16'h007F);
        link_fault = 7'h00;
        selftest();
        rdchk(LFG_RD_COND, 16'h0000);
        `CHK(lf_sum, 1'b0)
        u_ctrl.send(LFG_WR_ENAB, 16'h0040);
        `CHK(lf_sum, 1'b1)
        `CHK(stb_bit, 1'b0)
        u_ctrl.send(LFG_WR_ROUTE, 16'h0001);
        `CHK(stb_bit, 1'b0)
        u_ctrl.send(LFG_WR_ROUTE, 16'h0002);
        `CHK(stb_bit, 1'b0)
        u_ctrl.send(LFG_WR_ROUTE, 16'h0003);
        `CHK(stb_bit, 1'b1)
        rdchk(LFG_RD_ROUTE, 16'h0003);
        u_ctrl.send(LFG_CLS, 16'h0000);
        `CHK(lf_sum, 1'b0)
        rdchk(LFG_RD_EVENT, 16'h0000);
        // each parser error source alone sets the command error bit
        u_ctrl.send(LFG_WR_ESE, 16'hFFFF);
        rdchk(LFG_RD_ESE, 16'h00FF);
        for (int k = 0; k < 3; k++) begin
            u_ctrl.pulse(k);
            `CHK(std_sum, 1'b1)
            rdchk(LFG_RD_ESR, 16'h0020);
            `CHK(std_sum, 1'b0)
        end
        u_ctrl.pulse(0);
        u_ctrl.send(LFG_CLS, 16'h0000);
        rdchk(LFG_RD_ESR, 16'h0000);
        // second power cycle in mid-run
        RESETN_I = 1'b0;
        repeat (20) @(posedge CLK_I);
        #1;
        RESETN_I = 1'b1;
        rdchk(LFG_RD_ESR, 16'h0080);
        summarize();
    end
endmodule
